// *** core/tpcpwm_defs.svh ***
`ifndef TPCPWM_DEFS_SVH
`define TPCPWM_DEFS_SVH

// register byte offsets on the wishbone slave
`define TPC_OFS_CTRL       4'h0
`define TPC_OFS_IRQ_STAT   4'h4
`define TPC_OFS_IRQ_MASK   4'h8
`define TPC_OFS_STATUS     4'hC

// control register fields
`define TPC_CTRL_SOFT_EN   0
`define TPC_CTRL_RST       1'h1

// interrupt status / mask fields
`define TPC_IRQ_MID        0
`define TPC_IRQ_TOP        1
`define TPC_IRQ_BITS       2
`define TPC_IRQ_RST        2'h0

// status register fields
`define TPC_ST_CNT_LSB     0
`define TPC_ST_DIR         24
`define TPC_ST_RUN         25
`define TPC_ST_DEAD        26

// synchroniser fill time after reset release
`define TPC_SYNC_FILL      2

`endif

// *** core/tpcpwm_pkg.sv ***
package tpcpwm_pkg;

   typedef enum logic [1:0] {
      TPC_ST_DELAY,
      TPC_ST_DOWN,
      TPC_ST_UP
   } tpc_carrier_t;

   typedef struct packed {
      logic high;
      logic low;
   } tpc_leg_t;

   typedef struct packed {
      logic       mid;
      logic       top;
   } tpc_event_t;

endpackage

// *** core/tpcpwm.sv ***
// Overview of operation
// RQ1: The carrier counter runs as a triangle, counting down to zero, then up to the peak, then down again, without end.
// RQ2: The carrier counter keeps running whenever reset is released, regardless of the enable input.
// RQ3: Reset is asynchronous and active low, and every flip-flop runs on the single system clock.
// RQ4: The enable input gates all six drive outputs to zero at once while low, and lets them run while high.
// RQ5: Each phase has its own duty input, compared against the carrier scaled to the programmed period.
// RQ6: The period input sets the full carrier period in system clock cycles.
// RQ7: The high-side and low-side drives of each leg are complementary.
// RQ8: After one switch of a leg turns off, the opposite switch turns on only after the dead time has elapsed.
// RQ9: After reset release, carrier generation is held off for the configured delay time.
// RQ10: A mid-match event is raised when the carrier reaches its middle point, at the bottom of the triangle.
// RQ11: One width parameter sets the width of the duty, period, dead-time and delay inputs and counters.
// RQ12: The high-side command is active while duty exceeds the carrier, and the low-side command is its complement.
// RQ13: Dead time and delay time are counts of system clock cycles, like the period.
//
// Local design decisions: the Wishbone slave port and the register addresses.

`include "tpcpwm_defs.svh"

module tpcpwm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // two flops; the first is read by the second only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // tpcpwm_sync

module tpcpwm_leg
   import tpcpwm_pkg::*;
#(
   parameter int W = 18
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         run,
   input  wire logic         cmd,
   input  wire logic [W-1:0] dead,
   output tpc_leg_t          leg,
   output logic              in_dead
);
   logic         cur_r;
   logic [W-1:0] dt_cnt_r;
   tpc_leg_t     leg_r;

   assign leg     = leg_r;
   assign in_dead = (dt_cnt_r != '0);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cur_r    <= 1'b0;
         dt_cnt_r <= '0;
         leg_r    <= '0;
      end else if (!run) begin
         // restart with a full dead time so re-enabling never shoots through
         cur_r    <= cmd;
         dt_cnt_r <= dead;
         leg_r    <= '0;
      end else if (cmd != cur_r) begin
         cur_r    <= cmd;
         dt_cnt_r <= dead;                                  // [RQ8] [RQ13]
         leg_r    <= '0;                                    // [RQ8]
      end else if (dt_cnt_r != '0) begin
         dt_cnt_r <= dt_cnt_r - 1'b1;                       // [RQ8]
      end else begin
         leg_r.high <= cur_r;                               // [RQ7]
         leg_r.low  <= ~cur_r;                              // [RQ7]
      end
   end
endmodule // tpcpwm_leg

module TPCPWM
   import tpcpwm_pkg::*;
#(
   parameter int PORT_BIT_WIDTH = 18                        // [RQ11]
) (
   input  wire logic                      CLK,
   input  wire logic                      NRST,
   input  wire logic                      ENABLE,
   input  wire logic [PORT_BIT_WIDTH-1:0] DUTY_PHASE_A,
   input  wire logic [PORT_BIT_WIDTH-1:0] DUTY_PHASE_B,
   input  wire logic [PORT_BIT_WIDTH-1:0] DUTY_PHASE_C,
   input  wire logic [PORT_BIT_WIDTH-1:0] PWM_PERIOD,
   input  wire logic [PORT_BIT_WIDTH-1:0] DEAD_TIME,
   input  wire logic [PORT_BIT_WIDTH-1:0] DELAY_TIME,
   input  wire logic                      WB_CYC_I,
   input  wire logic                      WB_STB_I,
   input  wire logic                      WB_WE_I,
   input  wire logic [3:0]                WB_ADR_I,
   input  wire logic [31:0]               WB_DAT_I,
   input  wire logic [3:0]                WB_SEL_I,
   output logic      [31:0]               WB_DAT_O,
   output logic                           WB_ACK_O,
   output logic                           MID_MATCH,
   output logic                           IRQ,
   output logic                           DRIVE_A_HIGH,
   output logic                           DRIVE_A_LOW,
   output logic                           DRIVE_B_HIGH,
   output logic                           DRIVE_B_LOW,
   output logic                           DRIVE_C_HIGH,
   output logic                           DRIVE_C_LOW
);
   localparam int W = PORT_BIT_WIDTH;

   // ---------------- input synchronisers ----------------
   logic         en_s;
   logic [W-1:0] duty_s [3];
   logic [W-1:0] period_s;
   logic [W-1:0] dead_s;
   logic [W-1:0] delay_s;

   // word inputs are assumed quasi-static; duty and period are taken at each period top, dead and delay are used as synchronised
   tpcpwm_sync #(.W(1)) u_sync_en (
      .clk  (CLK),
      .nrst (NRST),
      .d    (ENABLE),
      .q    (en_s)
   );
   tpcpwm_sync #(.W(6*W)) u_sync_words (
      .clk  (CLK),
      .nrst (NRST),
      .d    ({DUTY_PHASE_A, DUTY_PHASE_B, DUTY_PHASE_C, PWM_PERIOD, DEAD_TIME, DELAY_TIME}),
      .q    ({duty_s[0], duty_s[1], duty_s[2], period_s, dead_s, delay_s})
   );

   // ---------------- carrier ----------------
   tpc_carrier_t state_r;
   logic [W-1:0] cnt_r;
   logic [W-1:0] peak_r;
   logic [W-1:0] dly_cnt_r;
   logic [1:0]   fill_r;
   logic         fill_done;
   tpc_event_t   ev;

   assign fill_done = (fill_r == 2'(`TPC_SYNC_FILL));
   assign ev.mid    = (state_r == TPC_ST_DOWN) && (cnt_r == '0);        // [RQ10]
   assign ev.top    = (state_r == TPC_ST_UP) && (cnt_r >= peak_r);

   // synchronised words are only trusted once the two flops have filled
   always_ff @(posedge CLK or negedge NRST) begin                     // [RQ3]
      if (!NRST) begin
         fill_r <= 2'h0;
      end else if (!fill_done) begin
         fill_r <= fill_r + 2'h1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin                     // [RQ3]
      if (!NRST) begin
         state_r   <= TPC_ST_DELAY;
         cnt_r     <= '0;
         peak_r    <= '0;
         dly_cnt_r <= '0;
      end else begin
         // the enable input plays no part here
         unique case (state_r)                                         // [RQ2]
            TPC_ST_DELAY: begin
               if (fill_done && dly_cnt_r >= delay_s) begin            // [RQ9] [RQ13]
                  state_r <= TPC_ST_DOWN;
                  peak_r  <= period_s >> 1;                            // [RQ6]
                  cnt_r   <= period_s >> 1;
               end else if (fill_done) begin
                  dly_cnt_r <= dly_cnt_r + 1'b1;                       // [RQ9]
               end
            end
            TPC_ST_DOWN: begin
               if (cnt_r == '0) begin
                  state_r <= TPC_ST_UP;                                // [RQ1]
                  if (peak_r != '0) begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end else begin
                  cnt_r <= cnt_r - 1'b1;                               // [RQ1]
               end
            end
            TPC_ST_UP: begin
               if (cnt_r >= peak_r) begin
                  state_r <= TPC_ST_DOWN;                              // [RQ1]
                  peak_r  <= period_s >> 1;                            // [RQ6]
                  cnt_r   <= (period_s >> 1) - ((period_s > 'd1) ? W'(1) : W'(0));
               end else begin
                  cnt_r <= cnt_r + 1'b1;                               // [RQ1]
               end
            end
         endcase
      end
   end

   // ---------------- duty compare and dead time ----------------
   logic [W-1:0] duty_r [3];
   logic [2:0]   cmd_r;
   logic [2:0]   in_dead;
   tpc_leg_t     leg [3];
   logic         run;
   logic         ctrl_soft_en_r;
   logic         words_ok_r;

   // legs wait one clock past the fill, so their first dead count is a real one
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         words_ok_r <= 1'b0;
      end else begin
         words_ok_r <= fill_done;                                      // [RQ8]
      end
   end

   assign run = en_s & ctrl_soft_en_r & words_ok_r;

   // duties are taken at the period top so a pulse is never cut mid-period
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         duty_r <= '{default: '0};
      end else if (ev.top || state_r == TPC_ST_DELAY) begin
         duty_r <= duty_s;                                             // [RQ5]
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cmd_r <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            // carrier spans half the period, so it is doubled to match duty
            cmd_r[i] <= (state_r != TPC_ST_DELAY) &&
                        ({1'b0, duty_r[i]} > {cnt_r, 1'b0});         // [RQ12] [RQ5]
         end
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_leg
      tpcpwm_leg #(.W(W)) u_leg (
         .clk     (CLK),
         .nrst    (NRST),
         .run     (run),
         .cmd     (cmd_r[g]),
         .dead    (dead_s),
         .leg     (leg[g]),
         .in_dead (in_dead[g])
      );
   end

   // the raw pin gates the flops so a disable acts without waiting for a clock
   assign DRIVE_A_HIGH = leg[0].high & ENABLE;                         // [RQ4]
   assign DRIVE_A_LOW  = leg[0].low  & ENABLE;                         // [RQ4]
   assign DRIVE_B_HIGH = leg[1].high & ENABLE;                         // [RQ4]
   assign DRIVE_B_LOW  = leg[1].low  & ENABLE;                         // [RQ4]
   assign DRIVE_C_HIGH = leg[2].high & ENABLE;                         // [RQ4]
   assign DRIVE_C_LOW  = leg[2].low  & ENABLE;                         // [RQ4]

   // ---------------- mid-match pulse ----------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         MID_MATCH <= 1'b0;
      end else begin
         MID_MATCH <= ev.mid;                                          // [RQ10]
      end
   end

   // ---------------- wishbone slave ----------------
   logic [`TPC_IRQ_BITS-1:0] irq_stat_r;
   logic [`TPC_IRQ_BITS-1:0] irq_mask_r;
   logic [`TPC_IRQ_BITS-1:0] irq_set;
   logic                     wb_req;
   logic                     wb_wr;
   logic [31:0]              rd_nxt;

   assign wb_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wb_wr   = wb_req & WB_WE_I & WB_SEL_I[0];
   assign irq_set = {ev.top, ev.mid};

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= wb_req;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_soft_en_r <= `TPC_CTRL_RST;
         irq_mask_r     <= `TPC_IRQ_RST;
      end else if (wb_wr) begin
         if (WB_ADR_I == `TPC_OFS_CTRL) begin
            ctrl_soft_en_r <= WB_DAT_I[`TPC_CTRL_SOFT_EN];
         end
         if (WB_ADR_I == `TPC_OFS_IRQ_MASK) begin
            irq_mask_r <= WB_DAT_I[`TPC_IRQ_BITS-1:0];
         end
      end
   end

   // a new event in the clearing cycle survives the write-one-to-clear
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         irq_stat_r <= `TPC_IRQ_RST;
      end else if (wb_wr && WB_ADR_I == `TPC_OFS_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~WB_DAT_I[`TPC_IRQ_BITS-1:0]) | irq_set;
      end else begin
         irq_stat_r <= irq_stat_r | irq_set;
      end
   end

   assign IRQ = |(irq_stat_r & irq_mask_r);

   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (WB_ADR_I)
         `TPC_OFS_CTRL:     rd_nxt[`TPC_CTRL_SOFT_EN] = ctrl_soft_en_r;
         `TPC_OFS_IRQ_STAT: rd_nxt[`TPC_IRQ_BITS-1:0] = irq_stat_r;
         `TPC_OFS_IRQ_MASK: rd_nxt[`TPC_IRQ_BITS-1:0] = irq_mask_r;
         `TPC_OFS_STATUS: begin
            rd_nxt[`TPC_ST_CNT_LSB +: 24] = 24'(cnt_r);
            rd_nxt[`TPC_ST_DIR]           = (state_r == TPC_ST_UP);
            rd_nxt[`TPC_ST_RUN]           = (state_r != TPC_ST_DELAY);
            rd_nxt[`TPC_ST_DEAD]          = |in_dead;
         end
         default:           rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (wb_req && !WB_WE_I) begin
         WB_DAT_O <= rd_nxt;
      end
   end

endmodule // TPCPWM

// *** tb/tpcpwm_sva.sv ***
module tpcpwm_sva
   import tpcpwm_pkg::*;
#(
   parameter int PORT_BIT_WIDTH = 18
) (
   input wire logic                      CLK,
   input wire logic                      NRST,
   input wire logic                      ENABLE,
   input wire logic [PORT_BIT_WIDTH-1:0] DEAD_TIME,
   input wire logic                      WB_CYC_I,
   input wire logic                      WB_STB_I,
   input wire logic                      WB_ACK_O,
   input wire logic                      MID_MATCH,
   input wire logic                      DRIVE_A_HIGH,
   input wire logic                      DRIVE_A_LOW,
   input wire logic                      DRIVE_B_HIGH,
   input wire logic                      DRIVE_B_LOW,
   input wire logic                      DRIVE_C_HIGH,
   input wire logic                      DRIVE_C_LOW
);
   logic [2:0]              hi;
   logic [2:0]              lo;
   logic [PORT_BIT_WIDTH:0] off_r [3];
   assign hi = {DRIVE_C_HIGH, DRIVE_B_HIGH, DRIVE_A_HIGH};
   assign lo = {DRIVE_C_LOW, DRIVE_B_LOW, DRIVE_A_LOW};
   // both-off run per leg; saturates so a long idle cannot wrap to a false gap
   always_ff @(posedge CLK or negedge NRST) begin
      for (int i = 0; i < 3; i++) begin
         if (!NRST) off_r[i] <= '0;
         else if (hi[i] | lo[i]) off_r[i] <= '0;
         else if (~&off_r[i]) off_r[i] <= off_r[i] + 1'b1;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence
   sequence s_take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   property p_gap_a;
      ($rose(hi[0]) || $rose(lo[0])) |-> off_r[0] >= DEAD_TIME + 1;
   endproperty
   property p_gap_b;
      ($rose(hi[1]) || $rose(lo[1])) |-> off_r[1] >= DEAD_TIME + 1;
   endproperty
   property p_gap_c;
      ($rose(hi[2]) || $rose(lo[2])) |-> off_r[2] >= DEAD_TIME + 1;
   endproperty
   property p_excl;
      (hi & lo) == 3'h0;
   endproperty
   property p_en;
      !ENABLE |-> hi == 3'h0 && lo == 3'h0;
   endproperty
   property p_mid;
      MID_MATCH |-> s_pulse(MID_MATCH);
   endproperty
   property p_ack;
      s_take |=> s_pulse(WB_ACK_O);
   endproperty
   property p_ack_one;
      WB_ACK_O |-> s_pulse(WB_ACK_O);
   endproperty
   a_gap_a: assert property (p_gap_a)
      else $error("leg a switched on inside its dead gap");
   a_gap_b: assert property (p_gap_b)
      else $error("leg b switched on inside its dead gap");
   a_gap_c: assert property (p_gap_c)
      else $error("leg c switched on inside its dead gap");
   a_excl: assert property (p_excl)
      else $error("both switches of a leg on");
   a_en: assert property (p_en)
      else $error("drive high while enable low");
   a_mid: assert property (p_mid)
      else $error("mid match longer than one cycle");
   a_ack: assert property (p_ack)
      else $error("bus request not answered next cycle");
   a_ack_one: assert property (p_ack_one)
      else $error("ack longer than one cycle");
endmodule // tpcpwm_sva

bind TPCPWM tpcpwm_sva #(.PORT_BIT_WIDTH(PORT_BIT_WIDTH)) sva_u (.CLK(CLK), .NRST(NRST),
   .ENABLE(ENABLE), .DEAD_TIME(DEAD_TIME), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_ACK_O(WB_ACK_O), .MID_MATCH(MID_MATCH), .DRIVE_A_HIGH(DRIVE_A_HIGH),
   .DRIVE_A_LOW(DRIVE_A_LOW), .DRIVE_B_HIGH(DRIVE_B_HIGH), .DRIVE_B_LOW(DRIVE_B_LOW),
   .DRIVE_C_HIGH(DRIVE_C_HIGH), .DRIVE_C_LOW(DRIVE_C_LOW));

// *** tb/tpcpwm_bridge.sv ***
module tpcpwm_bridge (
   input wire logic       clk,
   input wire logic [2:0] hi,
   input wire logic [2:0] lo,
   output int             shorts
);
   timeunit 1ns;
   timeprecision 1ns;
   // a real bridge shorts the rail when both switches of one leg conduct
   initial shorts = 0;
   always @(posedge clk) begin
      if ((hi & lo) != 3'h0) shorts <= shorts + 1;
   end
endmodule // tpcpwm_bridge

// *** tb/tpcpwm_tb.sv ***
`include "tpcpwm_defs.svh"
module tpcpwm_tb import tpcpwm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PER = 20;
   localparam int DEAD = 2;
   logic        clk = 1'b0, nrst = 1'b0, en = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat;
   logic [17:0] duty [3] = '{18'h8, 18'h8, 18'h8};
   logic [17:0] per = 18'h14, dead = 18'h2, delay = 18'h5;
   logic        ack, mid, irq;
   logic [2:0]  hi, lo;
   logic [7:0]  seed = 8'h51;
   int          num_errors = 0, checks_done = 0, cycles = 0, shorts;
   TPCPWM #(.PORT_BIT_WIDTH(18)) dut_u (.CLK(clk), .NRST(nrst), .ENABLE(en),
      .DUTY_PHASE_A(duty[0]), .DUTY_PHASE_B(duty[1]), .DUTY_PHASE_C(duty[2]),
      .PWM_PERIOD(per), .DEAD_TIME(dead), .DELAY_TIME(delay), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .MID_MATCH(mid), .IRQ(irq),
      .DRIVE_A_HIGH(hi[0]), .DRIVE_A_LOW(lo[0]), .DRIVE_B_HIGH(hi[1]),
      .DRIVE_B_LOW(lo[1]), .DRIVE_C_HIGH(hi[2]), .DRIVE_C_LOW(lo[2]));
   tpcpwm_bridge bridge_u (.clk(clk), .hi(hi), .lo(lo), .shorts(shorts));
   always #25 clk = ~clk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // command cycles per period: carrier walks peak..0..peak-1
   function automatic int cmd_on(input int d);
      int n;
      n = 0;
      for (int c = 0; c < PER; c++)
         if (d > 2 * (c <= PER / 2 ? PER / 2 - c : c - PER / 2)) n++;
      return n;
   endfunction
   // each turn-on loses the off gap of dead+1 clocks
   function automatic int exp_on(input int n);
      return (n == 0 || n == PER) ? n : (n > DEAD + 1 ? n - DEAD - 1 : 0);
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_mid(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (mid !== 1'b1);
   endtask
   task automatic measure(output int h[3], output int l[3]);
      h = '{0, 0, 0};
      l = '{0, 0, 0};
      repeat (PER) begin
         @(posedge clk);
         for (int i = 0; i < 3; i++) begin
            h[i] += (hi[i] === 1'b1);
            l[i] += (lo[i] === 1'b1);
         end
      end
   endtask
   task automatic do_reset(output int n);
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      wait_mid(n);
   endtask
   initial begin
      int          t5, t12, n;
      int          h[3], l[3], dv[3];
      logic [31:0] q;
      do_reset(t5);
      delay <= 18'hC;
      do_reset(t12);
      chk("start delay", 32'h7, t12 - t5);
      wait_mid(n);
      chk("carrier period", PER, n);
      wb(1'b0, `TPC_OFS_CTRL, 32'h0, 4'hF, q);
      chk("ctrl reset", 32'h1, q);
      wb(1'b0, 4'h2, 32'h0, 4'hF, q);
      chk("unmapped read", 32'h0, q);
      wb(1'b1, `TPC_OFS_IRQ_MASK, 32'h1, 4'hE, q);
      wb(1'b0, `TPC_OFS_IRQ_MASK, 32'h0, 4'hF, q);
      chk("mask after lane-less write", 32'h0, q);
      wb(1'b0, `TPC_OFS_STATUS, 32'h0, 4'hF, q);
      chk("running", 32'h1, {31'h0, q[`TPC_ST_RUN]});
      chk("carrier in range", 32'h1, {31'h0, q[23:0] <= PER / 2});
      wait_mid(n);
      wb(1'b0, `TPC_OFS_IRQ_STAT, 32'h0, 4'hF, q);
      chk("mid status", 32'h1, {31'h0, q[`TPC_IRQ_MID]});
      chk("top status", 32'h1, {31'h0, q[`TPC_IRQ_TOP]});
      chk("irq masked", 32'h0, {31'h0, irq});
      wb(1'b1, `TPC_OFS_IRQ_MASK, 32'h1, 4'hF, q);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wait_mid(n);
      wb(1'b1, `TPC_OFS_IRQ_STAT, 32'h1, 4'hF, q);
      chk("irq cleared", 32'h0, {31'h0, irq});
      for (int k = 0; k < 6; k++) begin
         for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            dv[i] = (k * 3 + i == 0) ? 0 : (k * 3 + i == 1) ? PER + 1 : 6 + seed % 11;
            duty[i] <= 18'(dv[i]);
         end
         repeat (3) wait_mid(n);
         measure(h, l);
         for (int i = 0; i < 3; i++) begin
            chk("high on time", exp_on(cmd_on(dv[i])), h[i]);
            chk("low on time", exp_on(PER - cmd_on(dv[i])), l[i]);
         end
      end
      en <= 1'b0;
      repeat (2) wait_mid(n);
      chk("period while disabled", PER, n);
      measure(h, l);
      chk("drives while disabled", 32'h0, h[0] + h[1] + h[2] + l[0] + l[1] + l[2]);
      en <= 1'b1;
      repeat (2) wait_mid(n);
      measure(h, l);
      chk("high after enable", exp_on(cmd_on(dv[2])), h[2]);
      wb(1'b1, `TPC_OFS_CTRL, 32'h0, 4'hF, q);
      measure(h, l);
      chk("drives soft off", 32'h0, h[0] + h[1] + h[2] + l[0] + l[1] + l[2]);
      wb(1'b1, `TPC_OFS_CTRL, 32'h1, 4'hF, q);
      repeat (2) wait_mid(n);
      measure(h, l);
      chk("low after soft on", exp_on(PER - cmd_on(dv[2])), l[2]);
      chk("rail shorts", 32'h0, shorts);
      stop_test();
   end
endmodule // tpcpwm_tb
